// [flow_readout_pkg.sv]
// Constants shared by the flow sample readout design
package flow_readout_pkg;

	// Clock and timing figures in their own units
	localparam int CLK_PERIOD_NS = 40;
	localparam int SAMPLE_PERIOD_US = 500;
	localparam int STARTUP_MS = 100;
	localparam int SOFT_RESET_MS = 80;

	// Derived cycle counts (each one rounds down)
	localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_US * 1000) / CLK_PERIOD_NS;
	localparam int STARTUP_CYCLES = (STARTUP_MS * 1000000) / CLK_PERIOD_NS;
	localparam int SOFT_RESET_CYCLES = (SOFT_RESET_MS * 1000000) / CLK_PERIOD_NS;
	localparam int TIMER_W = 22;

	// Result word format
	localparam logic [15:0] FLOW_OFFSET = 16'h8000;
	localparam logic [15:0] LOW_BITS_MASK = 16'hfffc;
	localparam logic signed [15:0] FLOW_LIMIT = 16'sh7530;
	localparam logic [15:0] WORD_RESET = 16'h8000;

	// Bus target
	localparam logic [6:0] TARGET_ADDR = 7'h40;
	localparam logic [7:0] SOFT_RESET_CMD = 8'hfe;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage

// [i2c_flow_target.sv]
// Serial bus target that serves the latest flow word, on the link clock
`timescale 1ns/100ps

module i2c_flow_target
	import flow_readout_pkg::*;
(
	input wire logic linkClk, // Oversampling link clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic scl, // Serial clock pin
	input wire logic sdaIn, // Data pin level
	input wire logic readyLvl, // Device ready, already synchronised
	input wire logic [15:0] wordIn, // Latest word, stable while read
	output logic sdaOe_n, // Data pin enable, low while driving low
	output logic softTgl // Toggles on each soft reset command
);

	typedef enum logic [2:0] {IDLE, ADDR, ADDR_ACK, WCMD, WACK, RDATA, RACK, RNEXT} tgt_state_t;

	tgt_state_t state_ff;
	logic sclA_ff, sclS_ff, sclQ_ff, sdaA_ff, sdaS_ff, sdaQ_ff;
	logic [3:0] cnt_ff;
	logic [7:0] shReg_ff;
	logic [15:0] rdWord_ff;
	logic byteSel_ff, oeN_ff, softTgl_ff;

	wire startSeen = sclS_ff && sclQ_ff && sdaQ_ff && !sdaS_ff;
	wire stopSeen = sclS_ff && sclQ_ff && !sdaQ_ff && sdaS_ff;
	wire sclRise = sclS_ff && !sclQ_ff;
	wire sclFall = !sclS_ff && sclQ_ff;
	wire addrHit = (shReg_ff[7:1] == TARGET_ADDR) && readyLvl;
	wire [7:0] curByte = byteSel_ff ? rdWord_ff[7:0] : rdWord_ff[15:8];
	wire [2:0] bitIdx = 3'h7 - cnt_ff[2:0];

	assign sdaOe_n = oeN_ff;
	assign softTgl = softTgl_ff;

	// Pin synchronisers; the first stage feeds only the second
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			{sclA_ff, sclS_ff, sclQ_ff} <= 3'h7;
			{sdaA_ff, sdaS_ff, sdaQ_ff} <= 3'h7;
		end else begin
			{sclA_ff, sclS_ff, sclQ_ff} <= {scl, sclA_ff, sclS_ff};
			{sdaA_ff, sdaS_ff, sdaQ_ff} <= {sdaIn, sdaA_ff, sdaS_ff};
		end
	end

	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= IDLE;
			cnt_ff <= 4'h0;
			shReg_ff <= 8'h00;
			rdWord_ff <= WORD_RESET;
			byteSel_ff <= 1'b0;
			oeN_ff <= 1'b1;
			softTgl_ff <= 1'b0;
		end else if (startSeen) begin
			state_ff <= ADDR;
			cnt_ff <= 4'h0;
			oeN_ff <= 1'b1;
		end else if (stopSeen) begin
			state_ff <= IDLE;
			oeN_ff <= 1'b1;
		end else begin
			case (state_ff)
				ADDR, WCMD: begin
					if (sclRise) begin
						shReg_ff <= {shReg_ff[6:0], sdaS_ff};
						cnt_ff <= cnt_ff + 4'h1;
					end else if (sclFall && cnt_ff == BITS_PER_BYTE) begin
						if (state_ff == WCMD) begin
							oeN_ff <= 1'b0;
							state_ff <= WACK;
							if (shReg_ff == SOFT_RESET_CMD) begin
								softTgl_ff <= !softTgl_ff;
							end
						end else if (addrHit) begin
							oeN_ff <= 1'b0;
							state_ff <= ADDR_ACK;
							rdWord_ff <= wordIn;
							byteSel_ff <= 1'b0;
						end else begin
							state_ff <= IDLE;
						end
					end
				end
				ADDR_ACK: begin
					if (sclFall) begin
						cnt_ff <= 4'h1;
						if (shReg_ff[0]) begin
							oeN_ff <= curByte[7];
							state_ff <= RDATA;
						end else begin
							oeN_ff <= 1'b1;
							cnt_ff <= 4'h0;
							state_ff <= WCMD;
						end
					end
				end
				WACK: begin
					if (sclFall) begin
						oeN_ff <= 1'b1;
						cnt_ff <= 4'h0;
						state_ff <= WCMD;
					end
				end
				RDATA: begin
					if (sclFall) begin
						if (cnt_ff == BITS_PER_BYTE) begin
							oeN_ff <= 1'b1;
							state_ff <= RACK;
						end else begin
							oeN_ff <= curByte[bitIdx];
							cnt_ff <= cnt_ff + 4'h1;
						end
					end
				end
				RACK: begin
					if (sclRise) begin
						// Host acks the first byte; a nack ends the transfer
						state_ff <= sdaS_ff ? IDLE : RNEXT;
						byteSel_ff <= !byteSel_ff;
					end
				end
				RNEXT: begin
					if (sclFall) begin
						oeN_ff <= curByte[7];
						cnt_ff <= 4'h1;
						state_ff <= RDATA;
					end
				end
				default: begin
					oeN_ff <= 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	a_nack_unready: assert property (@(posedge linkClk) disable iff (!rst_n)
		(state_ff == ADDR_ACK) |-> readyLvl || $past(readyLvl))
		else $error("address acknowledged while not ready");
	a_stop_release: assert property (@(posedge linkClk) disable iff (!rst_n)
		stopSeen |=> oeN_ff && state_ff == IDLE)
		else $error("data pin not released after stop");
	c_read_two: cover property (@(posedge linkClk) disable iff (!rst_n)
		state_ff == RNEXT);
	c_soft_cmd: cover property (@(posedge linkClk) disable iff (!rst_n)
		$changed(softTgl_ff));

endmodule

// [flow_sample_readout.sv]
// Flow sample readout: sample timing, result word, readiness and bus target
`timescale 1ns/100ps

// Function
// - A new flow result is produced every half millisecond.
// - Each result is a 16-bit word with its two lowest bits always zero.
// - The device is ready within 100 ms of power-up and refuses the bus before.
// - Results span plus and minus 250 slm, above the offset meaning positive flow.
// - Flow from the female to the male side reads positive.
module flow_sample_readout
	import flow_readout_pkg::*;
#(
	parameter int SAMPLE_CNT = SAMPLE_CYCLES,
	parameter int STARTUP_CNT = STARTUP_CYCLES,
	parameter int SOFTRST_CNT = SOFT_RESET_CYCLES
) (
	input wire logic clock, // System clock, 25 MHz
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic linkClk, // Link oversampling clock
	input wire logic signed [15:0] flowIn, // Flow times 120, female to male positive
	input wire logic scl, // Serial clock pin
	input wire logic sdaIn, // Data pin level
	output logic sdaOut, // Data pin drive value, always low
	output logic sdaOe_n, // Data pin enable, low while driving
	output logic ready, // Device ready for the bus
	output logic [15:0] sampleWord, // Latest result word
	output logic sampleStrobe // One cycle when a result is taken
);

	logic [TIMER_W-1:0] sampCnt_ff, readyCnt_ff;
	logic ready_ff, strobe_ff, sdaOut_ff;
	logic [15:0] word_ff;
	logic softA_ff, softS_ff, softQ_ff;
	logic rdyA_ff, rdyS_ff;
	logic linkSoftTgl, linkOe_n;
	logic wordTgl_ff, wTglA_ff, wTglS_ff, wTglQ_ff;
	logic [15:0] linkWord_ff;

	////////////////////////////////////////////////////////////////////////////
	// Result word
	wire sampleDue = (sampCnt_ff == TIMER_W'(SAMPLE_CNT - 1));
	wire signed [15:0] flowClamped = (flowIn > FLOW_LIMIT) ? FLOW_LIMIT :
		(flowIn < -FLOW_LIMIT) ? -FLOW_LIMIT : flowIn;
	wire [15:0] nxt_word = (FLOW_OFFSET + 16'(flowClamped)) & LOW_BITS_MASK;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sampCnt_ff <= '0;
		end else begin
			sampCnt_ff <= sampleDue ? '0 : sampCnt_ff + 1'b1;
		end
	end

	// Word is held for a full period so the link side can copy it safely
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			word_ff <= WORD_RESET;
			strobe_ff <= 1'b0;
		end else begin
			strobe_ff <= sampleDue;
			if (sampleDue) begin
				word_ff <= nxt_word;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Readiness after power-up and soft reset
	wire softEdge = softS_ff ^ softQ_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{softA_ff, softS_ff, softQ_ff} <= 3'h0;
		end else begin
			{softA_ff, softS_ff, softQ_ff} <= {linkSoftTgl, softA_ff, softS_ff};
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			readyCnt_ff <= TIMER_W'(STARTUP_CNT);
			ready_ff <= 1'b0;
		end else if (softEdge) begin
			readyCnt_ff <= TIMER_W'(SOFTRST_CNT);
			ready_ff <= 1'b0;
		end else begin
			if (readyCnt_ff != '0) begin
				readyCnt_ff <= readyCnt_ff - 1'b1;
			end
			ready_ff <= (readyCnt_ff == '0);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Word crossing; the toggle passes two flops before the link side copies,
	// and the word then stands for a whole sample period, so no bit can tear
	wire linkWordEdge = wTglS_ff ^ wTglQ_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wordTgl_ff <= 1'b0;
		end else if (sampleDue) begin
			wordTgl_ff <= !wordTgl_ff;
		end
	end

	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			{wTglA_ff, wTglS_ff, wTglQ_ff} <= 3'h0;
			linkWord_ff <= WORD_RESET;
		end else begin
			{wTglA_ff, wTglS_ff, wTglQ_ff} <= {wordTgl_ff, wTglA_ff, wTglS_ff};
			if (linkWordEdge) begin
				linkWord_ff <= word_ff;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link side; ready crosses as a level
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			{rdyA_ff, rdyS_ff} <= 2'h0;
		end else begin
			{rdyA_ff, rdyS_ff} <= {ready_ff, rdyA_ff};
		end
	end

	i2c_flow_target u_target (
		.linkClk(linkClk),
		.rst_n(rst_n),
		.scl(scl),
		.sdaIn(sdaIn),
		.readyLvl(rdyS_ff),
		.wordIn(linkWord_ff),
		.sdaOe_n(linkOe_n),
		.softTgl(linkSoftTgl)
	);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sdaOut_ff <= 1'b0;
		end else begin
			sdaOut_ff <= 1'b0;
		end
	end

	assign sdaOut = sdaOut_ff;
	assign sdaOe_n = linkOe_n;
	assign ready = ready_ff;
	assign sampleWord = word_ff;
	assign sampleStrobe = strobe_ff;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	logic [TIMER_W-1:0] sinceStrobe_ff, notReadyCnt_ff;
	logic seenStrobe_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sinceStrobe_ff <= '0;
			seenStrobe_ff <= 1'b0;
			notReadyCnt_ff <= '0;
		end else begin
			sinceStrobe_ff <= strobe_ff ? '0 : sinceStrobe_ff + 1'b1;
			seenStrobe_ff <= seenStrobe_ff | strobe_ff;
			notReadyCnt_ff <= ready_ff ? '0 : notReadyCnt_ff + 1'b1;
		end
	end

	a_sample_period: assert property (@(posedge clock) disable iff (!rst_n)
		strobe_ff && seenStrobe_ff |-> sinceStrobe_ff == TIMER_W'(SAMPLE_CNT - 1))
		else $error("sample spacing is not half a millisecond");
	a_low_bits: assert property (@(posedge clock) disable iff (!rst_n)
		strobe_ff |-> word_ff[1:0] == 2'h0)
		else $error("low word bits not zero");
	a_flow_span: assert property (@(posedge clock) disable iff (!rst_n)
		strobe_ff |-> word_ff >= 16'h0ad0 && word_ff <= 16'hf530)
		else $error("result outside flow span");
	a_sign_map: assert property (@(posedge clock) disable iff (!rst_n)
		sampleDue && flowIn > 16'sh0003 |=> word_ff > FLOW_OFFSET)
		else $error("positive flow not above offset");
	a_startup_bound: assert property (@(posedge clock) disable iff (!rst_n)
		!ready_ff |-> notReadyCnt_ff <= TIMER_W'(STARTUP_CNT + 1))
		else $error("device not ready in time");
	a_soft_drop: assert property (@(posedge clock) disable iff (!rst_n)
		softEdge |=> !ready_ff ##1 !ready_ff)
		else $error("soft reset did not drop ready");
	a_ready_hold: assert property (@(posedge clock) disable iff (!rst_n)
		ready_ff && !softEdge |=> ready_ff)
		else $error("ready dropped without soft reset");
	a_strobe_single: assert property (@(posedge clock) disable iff (!rst_n)
		strobe_ff |=> !strobe_ff)
		else $error("sample strobe longer than one cycle");
	a_word_stable: assert property (@(posedge clock) disable iff (!rst_n)
		!strobe_ff |-> $stable(word_ff))
		else $error("result word changed without strobe");
	a_clamp_high: assert property (@(posedge clock) disable iff (!rst_n)
		sampleDue && flowIn > FLOW_LIMIT |=> word_ff == 16'hf530)
		else $error("high flow not clamped to span");
	a_clamp_low: assert property (@(posedge clock) disable iff (!rst_n)
		sampleDue && flowIn < -FLOW_LIMIT |=> word_ff == 16'h0ad0)
		else $error("low flow not clamped to span");
	a_sign_neg: assert property (@(posedge clock) disable iff (!rst_n)
		sampleDue && flowIn < 16'sh0000 |=> word_ff < FLOW_OFFSET)
		else $error("negative flow not below offset");

	// Link domain check, then covers on the system clock
	a_link_copy: assert property (@(posedge linkClk) disable iff (!rst_n)
		linkWordEdge |=> linkWord_ff == word_ff)
		else $error("link copy of result word differs");
	c_first_sample: cover property (@(posedge clock) disable iff (!rst_n)
		strobe_ff && ready_ff);
	c_ready_rise: cover property (@(posedge clock) disable iff (!rst_n)
		$rose(ready_ff));
	c_soft_reset: cover property (@(posedge clock) disable iff (!rst_n)
		softEdge);

endmodule

// [i2c_host_model.sv]
// Serial bus host model that reads and commands the flow readout
`timescale 1ns/100ps

module i2c_host_model #(
	parameter int QTR = 100
) (
	input wire logic sdaOe_n, // Target pull-down, low while driving
	output logic scl, // Serial clock, idle high
	output logic sda // Resolved data line
);
	logic hostSda;

	// Open drain with pull-up: low if either party pulls
	assign sda = hostSda & sdaOe_n;

	initial begin
		scl = 1'b1;
		hostSda = 1'b1;
	end

	////////////////////////////////////////
	task automatic start();
		hostSda = 1'b0;
		#QTR scl = 1'b0;
		#QTR;
	endtask

	task automatic stop();
		hostSda = 1'b0;
		#QTR scl = 1'b1;
		#QTR hostSda = 1'b1;
		#QTR;
	endtask

	// Data moves only while the clock is low, so no false start or stop
	task automatic bitx(input logic b, output logic r);
		hostSda = b;
		#QTR scl = 1'b1;
		#QTR r = sda;
		scl = 1'b0;
		#QTR;
	endtask

	task automatic xfer(input logic [7:0] tx, input logic ackOut, output logic [7:0] rx,
		output logic nak);
		for (int i = 7; i >= 0; i--)
			bitx(tx[i], rx[i]);
		bitx(ackOut, nak);
	endtask

	task automatic readWord(input logic [6:0] addr, output logic nak, output logic [15:0] w);
		logic a;
		start();
		xfer({addr, 1'b1}, 1'b1, w[15:8], nak);
		if (!nak) begin
			xfer(8'hff, 1'b0, w[15:8], a);
			xfer(8'hff, 1'b1, w[7:0], a);
		end
		stop();
	endtask

	task automatic writeCmd(input logic [6:0] addr, input logic [7:0] cmd, output logic nak);
		logic [7:0] x;
		logic a;
		start();
		xfer({addr, 1'b0}, 1'b1, x, nak);
		xfer(cmd, 1'b1, x, a);
		stop();
	endtask
endmodule

// [tb_top.sv]
// Testbench for the flow sample readout with a serial bus host model
`timescale 1ns/100ps

module tb_top;
	import flow_readout_pkg::*;

	localparam int SCNT = 20;
	localparam int UCNT = 400;
	localparam int RCNT = 200;

	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic linkClk = 1'b0;
	logic signed [15:0] flowIn = 16'sh0000;
	logic scl;
	logic sda;
	logic sdaOe_n;
	logic sdaOut;
	logic ready;
	logic sampleStrobe;
	logic [15:0] sampleWord;
	int miscompares = 0;
	int n_checks = 0;

	always #20 clock = ~clock;

	// Odd start keeps the link clock out of phase with the system clock
	initial begin
		#1.3;
		forever #3 linkClk = ~linkClk;
	end

	flow_sample_readout #(.SAMPLE_CNT(SCNT), .STARTUP_CNT(UCNT), .SOFTRST_CNT(RCNT)) uut (
		.clock(clock), .rst_n(rst_n), .linkClk(linkClk), .flowIn(flowIn), .scl(scl),
		.sdaIn(sda), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .ready(ready),
		.sampleWord(sampleWord), .sampleStrobe(sampleStrobe));

	i2c_host_model host (.sdaOe_n(sdaOe_n), .scl(scl), .sda(sda));

	////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [15:0] expWord(input logic signed [15:0] f);
		logic signed [15:0] c;
		c = (f > FLOW_LIMIT) ? FLOW_LIMIT : ((f < -FLOW_LIMIT) ? -FLOW_LIMIT : f);
		return (c + FLOW_OFFSET) & LOW_BITS_MASK;
	endfunction

	task automatic waitFor(input bit onReady, input logic lvl, output int n);
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while ((onReady ? ready : sampleStrobe) !== lvl && n < 1000);
	endtask

	task automatic tReset();
		@(negedge clock);
		rst_n = 1'b0;
		repeat (8) @(negedge clock);
		check("word", WORD_RESET, sampleWord);
		check("sda drive", 16'h0000, 16'(sdaOut));
		check("ready", 16'h0000, 16'(ready));
		check("oe", 16'h0001, 16'(sdaOe_n));
		check("strobe", 16'h0000, 16'(sampleStrobe));
		rst_n = 1'b1;
	endtask

	task automatic tStartup();
		int n;
		logic nak;
		logic [15:0] w;
		fork
			waitFor(1'b1, 1'b1, n);
			host.readWord(TARGET_ADDR, nak, w);
		join
		check("ready edges", 16'(UCNT + 1), 16'(n));
		check("early nak", 16'h0001, 16'(nak));
	endtask

	task automatic tSamples();
		logic signed [15:0] vals [7] = '{16'sh0000, 16'sh0078, 16'shff88, 16'sh7530,
			16'sh7531, 16'sh8000, 16'sh0007};
		int n;
		int gap = 0;
		waitFor(1'b0, 1'b1, n);
		foreach (vals[i]) begin
			@(negedge clock);
			flowIn = vals[i];
			waitFor(1'b0, 1'b1, n);
			check("period", 16'(SCNT), 16'(n + gap));
			check("word", expWord(vals[i]), sampleWord);
			@(posedge clock);
			#1;
			check("pulse", 16'h0000, 16'(sampleStrobe));
			gap = 1;
		end
	endtask

	task automatic tRead();
		logic nak;
		logic [15:0] w;
		int f;
		@(negedge clock);
		flowIn = 16'shfb50;
		repeat (2 * SCNT) @(negedge clock);
		host.readWord(TARGET_ADDR, nak, w);
		check("read nak", 16'h0000, 16'(nak));
		check("read word", expWord(16'shfb50), w);
		f = w;
		check("read flow", 16'hfff6, 16'((f - 32768) / 120));
		check("oe idle", 16'h0001, 16'(sdaOe_n));
		host.readWord(TARGET_ADDR + 7'h01, nak, w);
		check("stray nak", 16'h0001, 16'(nak));
	endtask

	task automatic tSoftReset();
		logic nak;
		int n;
		@(negedge clock);
		host.writeCmd(TARGET_ADDR, SOFT_RESET_CMD, nak);
		check("cmd nak", 16'h0000, 16'(nak));
		check("ready low", 16'h0000, 16'(ready));
		waitFor(1'b1, 1'b1, n);
		check("reset span", 16'h0001, 16'(n > RCNT - 40 && n <= RCNT));
	endtask

	task automatic conclude();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		tReset();
		tStartup();
		tSamples();
		tRead();
		tSoftReset();
		tReset();
		conclude();
	end

	// Whole run needs well under a quarter of this span
	initial begin
		#400000;
		miscompares++;
		$display("[ERR] watchdog expected done seen hang");
		conclude();
	end
endmodule
